// ---- hw/tpcdm_top.sv ----
// Transmit all-ones select, build-out select and drive monitor with a Wishbone slave.
`include "tpcdm_regs.svh"
`timescale 1ns/100ps
`default_nettype none
// The transmit clock arrives as a rate enable pulse from the board divider;
// all counting is done in transmit clock periods, so 125 MHz sets no figure.
module tpcdm_top (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic transmit_clock,
  input wire logic all_ones_select,
  input wire logic build_out_select,
  input wire logic monitor_in_pos,
  input wire logic monitor_in_neg,
  input wire logic data_pos,
  input wire logic data_neg,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic line_out_pos,
  output logic line_out_neg,
  output logic build_out_en,
  output logic drive_monitor_flag,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl_r;
  logic [`TPCDM_IRQ_BITS-1:0] irq_stat_r;
  logic [`TPCDM_IRQ_BITS-1:0] irq_mask_r;
  logic [`TPCDM_IRQ_BITS-1:0] irq_evt;
  logic [`TPCDM_CNT_W-1:0] idle_cnt_r;
  logic polarity_r;
  logic flag_nxt;
  logic host_mode;
  logic high_rate;
  logic all_ones_on;
  logic mon_pulse;
  logic wr_stb;
  logic [31:0] rd_data;
  tpcdm_pkg::tpcdm_rate_e rate;

  assign host_mode = ctrl_r[`TPCDM_CTRL_HOST_MODE];
  assign rate = tpcdm_pkg::tpcdm_rate_e'(ctrl_r[`TPCDM_CTRL_RATE_HI:`TPCDM_CTRL_RATE_LO]);
  assign high_rate = (rate == tpcdm_pkg::TPCDM_RATE_DS3) || (rate == tpcdm_pkg::TPCDM_RATE_STS1);
  assign all_ones_on = all_ones_select && !host_mode;
  // Either rail high is a bipolar mark seen on the line.
  assign mon_pulse = monitor_in_pos || monitor_in_neg;

  ////////////////////////////////////////////////////////////////////////////
  // Line output: in all-ones mode the mark alternates rails each period.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      line_out_pos <= 1'b0;
      line_out_neg <= 1'b0;
      polarity_r <= 1'b0;
    end else if (transmit_clock) begin
      if (!ctrl_r[`TPCDM_CTRL_TX_EN]) begin
        line_out_pos <= 1'b0;
        line_out_neg <= 1'b0;
      end else if (all_ones_on) begin
        line_out_pos <= !polarity_r;
        line_out_neg <= polarity_r;
        polarity_r <= !polarity_r;
      end else begin
        line_out_pos <= data_pos;
        line_out_neg <= data_neg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Build-out enable; outside DS3/STS-1 hardware mode the stage stays enabled.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      build_out_en <= 1'b1;
    end else if (high_rate && !host_mode) begin
      build_out_en <= !build_out_select;
    end else begin
      build_out_en <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive monitor. The count saturates so the flag cannot fall by wrap-around.
  always_comb begin
    flag_nxt = drive_monitor_flag;
    if (mon_pulse) begin
      flag_nxt = 1'b0;
    end else if (transmit_clock && (idle_cnt_r == `TPCDM_CNT_W'(`TPCDM_DMON_PERIODS - 1))) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      idle_cnt_r <= '0;
    end else if (mon_pulse) begin
      idle_cnt_r <= '0;
    end else if (transmit_clock && (idle_cnt_r != `TPCDM_CNT_W'(`TPCDM_DMON_PERIODS - 1))) begin
      idle_cnt_r <= idle_cnt_r + `TPCDM_CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      drive_monitor_flag <= 1'b0;
    end else begin
      drive_monitor_flag <= flag_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: flag rise and flag fall events, write one to clear.
  assign irq_evt[`TPCDM_IRQ_FLAG_SET] = flag_nxt && !drive_monitor_flag;
  assign irq_evt[`TPCDM_IRQ_FLAG_CLR] = !flag_nxt && drive_monitor_flag;
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_r <= '0;
    end else begin
      // A new event wins over a clear written in the same cycle.
      if (wr_stb && wb_adr_i == `TPCDM_ADR_IRQ_STAT && wb_sel_i[0]) begin
        irq_stat_r <= (irq_stat_r & ~wb_dat_i[`TPCDM_IRQ_BITS-1:0]) | irq_evt;
      end else begin
        irq_stat_r <= irq_stat_r | irq_evt;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone registers, byte lane 0 only carries defined bits.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= `TPCDM_CTRL_RESET;
      irq_mask_r <= '0;
    end else if (wr_stb && wb_sel_i[0]) begin
      if (wb_adr_i == `TPCDM_ADR_CTRL) begin
        ctrl_r <= {28'h0000000, wb_dat_i[3:0]};
      end
      if (wb_adr_i == `TPCDM_ADR_IRQ_MASK) begin
        irq_mask_r <= wb_dat_i[`TPCDM_IRQ_BITS-1:0];
      end
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      `TPCDM_ADR_CTRL: rd_data = ctrl_r;
      `TPCDM_ADR_STAT: begin
        rd_data[`TPCDM_STAT_FLAG] = drive_monitor_flag;
        rd_data[`TPCDM_STAT_BUILD_OUT] = build_out_en;
        rd_data[`TPCDM_STAT_ALL_ONES] = all_ones_on;
      end
      `TPCDM_ADR_IRQ_STAT: rd_data[`TPCDM_IRQ_BITS-1:0] = irq_stat_r;
      `TPCDM_ADR_IRQ_MASK: rd_data[`TPCDM_IRQ_BITS-1:0] = irq_mask_r;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Ack one cycle after the strobe, then drop; unmapped addresses read zero.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= rd_data;
    end
  end

endmodule
`default_nettype wire

// ---- hw/tpcdm_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the transmit pin control block.
`ifndef TPCDM_REGS_SVH
`define TPCDM_REGS_SVH
`define TPCDM_ADR_CTRL 4'h0
`define TPCDM_ADR_STAT 4'h4
`define TPCDM_ADR_IRQ_STAT 4'h8
`define TPCDM_ADR_IRQ_MASK 4'hc
`define TPCDM_CTRL_HOST_MODE 0
`define TPCDM_CTRL_RATE_LO 1
`define TPCDM_CTRL_RATE_HI 2
`define TPCDM_CTRL_TX_EN 3
`define TPCDM_CTRL_RESET 32'h0000_0008
`define TPCDM_STAT_FLAG 0
`define TPCDM_STAT_BUILD_OUT 1
`define TPCDM_STAT_ALL_ONES 2
`define TPCDM_IRQ_FLAG_SET 0
`define TPCDM_IRQ_FLAG_CLR 1
`define TPCDM_IRQ_BITS 2
`define TPCDM_DMON_PERIODS 128
`define TPCDM_CNT_W 8
`endif

// ---- hw/tpcdm_pkg.sv ----
// Types shared by the transmit pin control and drive monitor block.
package tpcdm_pkg;
  typedef enum logic [1:0] {
    TPCDM_RATE_E3 = 2'h0,
    TPCDM_RATE_DS3 = 2'h1,
    TPCDM_RATE_STS1 = 2'h2,
    TPCDM_RATE_RSVD = 2'h3
  } tpcdm_rate_e;
  typedef enum logic [2:0] {
    TPCDM_ST_IDLE = 3'b001,
    TPCDM_ST_ACK = 3'b010,
    TPCDM_ST_GAP = 3'b100
  } tpcdm_bus_e;
endpackage

// ---- verif/tpcdm_chk.sv ----
// Port checker for the transmit pin control block.
`timescale 1ns/100ps
`default_nettype none
module tpcdm_chk (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic transmit_clock,
  input wire logic monitor_in_pos,
  input wire logic monitor_in_neg,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic line_out_pos,
  input wire logic line_out_neg,
  input wire logic drive_monitor_flag
);
  logic [8:0] quiet_r;
  wire logic mon = monitor_in_pos | monitor_in_neg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Our own pulse-free count, saturating so a stuck flag cannot wrap it back to zero.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      quiet_r <= 9'h0;
    else if (mon)
      quiet_r <= 9'h0;
    else if (transmit_clock && !quiet_r[8])
      quiet_r <= quiet_r + 9'h1;
  end
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  AST_ACK_TIME: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_AMI_RAIL: assert property (!(line_out_pos && line_out_neg))
    else $error("both rails high");
  AST_LINE_HOLD: assert property (!$past(transmit_clock) |-> $stable({line_out_pos, line_out_neg}))
    else $error("line moved off clock");
  AST_FLAG_CLEAR: assert property (mon |=> !drive_monitor_flag)
    else $error("flag kept after pulse");
  AST_FLAG_KEEP: assert property (drive_monitor_flag && !mon |=> drive_monitor_flag)
    else $error("flag dropped early");
  AST_FLAG_COUNT: assert property ($rose(drive_monitor_flag) |-> quiet_r == 9'h80)
    else $error("flag rose at wrong count");
  AST_FLAG_DUE: assert property (quiet_r >= 9'h80 |-> drive_monitor_flag)
    else $error("flag missing");
endmodule
`default_nettype wire

// ---- verif/tpcdm_line_model.sv ----
// Transformer loop back to the monitor inputs and the installer's build-out choice.
`timescale 1ns/100ps
`default_nettype none
module tpcdm_line_model (
  input wire logic line_out_pos,
  input wire logic line_out_neg,
  input wire logic [11:0] cable_ft,
  output logic monitor_in_pos,
  output logic monitor_in_neg,
  output logic build_out_select
);
  assign monitor_in_pos = line_out_pos;
  assign monitor_in_neg = line_out_neg;
  assign build_out_select = cable_ft > 12'he1;
endmodule
`default_nettype wire

// ---- verif/test_tx_pin_control_drive_monitor.sv ----
// Self-checking bench for the transmit pin control block.
`timescale 1ns/100ps
`default_nettype none
module test_tx_pin_control_drive_monitor;
  typedef struct packed {logic [3:0] ctrl; logic [11:0] ft; logic ao, boe, ones;} tpcdm_row_s;
  localparam tpcdm_row_s ROWS [6] = '{'{4'h8, 12'h12c, 1'h1, 1'h1, 1'h1},
    '{4'ha, 12'h12c, 1'h0, 1'h0, 1'h0}, '{4'hc, 12'h12c, 1'h1, 1'h0, 1'h1},
    '{4'hc, 12'h064, 1'h0, 1'h1, 1'h0}, '{4'hb, 12'h12c, 1'h1, 1'h1, 1'h0},
    '{4'h9, 12'h064, 1'h1, 1'h1, 1'h0}};
  logic ref_clk = 1'h0, nrst = 1'h0, transmit_clock = 1'h0, all_ones_select = 1'h0;
  logic data_pos = 1'h0;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, rdata;
  logic [11:0] cable_ft = 12'h064;
  logic [1:0] first;
  wire logic [31:0] wb_dat_o;
  wire logic build_out_select, monitor_in_pos, monitor_in_neg, line_out_pos, line_out_neg;
  wire logic wb_ack_o, build_out_en, drive_monitor_flag, irq;
  int error_cnt = 0, tests_run = 0, cycles = 0;
  tpcdm_top dut (.ref_clk, .nrst, .transmit_clock, .all_ones_select, .build_out_select,
    .monitor_in_pos, .monitor_in_neg, .data_pos, .data_neg(1'h0), .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .line_out_pos, .line_out_neg, .build_out_en, .drive_monitor_flag, .irq);
  tpcdm_line_model far (.line_out_pos, .line_out_neg, .cable_ft, .monitor_in_pos,
    .monitor_in_neg, .build_out_select);
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      complete_run;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    @(posedge ref_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    do @(posedge ref_clk); while (wb_ack_o !== 1'h1);
    rdata = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  // Ends one edge after the last pulse so the line and flag updates have landed.
  task tcs(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      transmit_clock <= 1'h1;
      @(posedge ref_clk);
      transmit_clock <= 1'h0;
    end
    @(posedge ref_clk);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge ref_clk);
    nrst <= 1'h1;
    // A standing payload mark shows whether all-ones really overrides the data.
    data_pos <= 1'h1;
    foreach (ROWS[i]) begin
      wb(1'h1, 4'h0, {28'h0, ROWS[i].ctrl});
      cable_ft <= ROWS[i].ft;
      all_ones_select <= ROWS[i].ao;
      tcs(1);
      first = {line_out_pos, line_out_neg};
      tcs(1);
      chk(build_out_en, ROWS[i].boe);
      chk({first, line_out_pos, line_out_neg}, ROWS[i].ones ?
        {first[1], ~first[1], ~first[1], first[1]} : 4'ha);
    end
    all_ones_select <= 1'h0;
    data_pos <= 1'h0;
    nrst <= 1'h0;
    repeat (2) @(posedge ref_clk);
    chk({line_out_pos, line_out_neg, drive_monitor_flag, irq, wb_ack_o, build_out_en}, 6'h01);
    nrst <= 1'h1;
    wb(1'h0, 4'h0, 32'h0);
    chk(rdata, 32'h8);
    wb(1'h0, 4'h2, 32'h0);
    chk(rdata, 32'h0);
    tcs(100);
    all_ones_select <= 1'h1;
    tcs(1);
    all_ones_select <= 1'h0;
    tcs(128);
    chk(drive_monitor_flag, 1'h0);
    tcs(1);
    chk({drive_monitor_flag, irq}, 2'h2);
    wb(1'h1, 4'hc, 32'h1);
    @(posedge ref_clk);
    chk(irq, 1'h1);
    wb(1'h0, 4'h8, 32'h0);
    chk(rdata, 32'h1);
    wb(1'h1, 4'h8, 32'h1);
    @(posedge ref_clk);
    chk({drive_monitor_flag, irq}, 2'h2);
    all_ones_select <= 1'h1;
    tcs(1);
    @(posedge ref_clk);
    chk(drive_monitor_flag, 1'h0);
    wb(1'h0, 4'h8, 32'h0);
    chk(rdata, 32'h2);
    complete_run;
  end
endmodule
bind tpcdm_top tpcdm_chk chk (.ref_clk, .nrst, .transmit_clock, .monitor_in_pos,
  .monitor_in_neg, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .line_out_pos, .line_out_neg,
  .drive_monitor_flag);
`default_nettype wire
